// ### logic/eis_irq_ctrl.sv
// External request sense, pending flags and transfer activation enables on APB
// Notes on behaviour
// RL1: Each of eight inputs has a two-bit sense field; seven-four high, three-zero low.
// RL2: Sense code 00 low level, 01 falling, 10 rising, 11 both edges.
// RL3: Low sense byte sits at index ff2d; all sense fields reset to zero.
// RL4: One pending flag per input, bit n for input n, reset to zero.
// RL5: Software clears a pending flag by writing zero; writing one does nothing.
// RL6: One activation enable per source, reset zero; one routes source to transfer controller.
// RL7: Enable clears itself after a transfer with disable option or exhausted count.
// RL8: Enable stays set when disable option is zero and count remains.
// RL9: First enable byte maps bit seven to input zero, bit zero to input seven.
// RL10: Activation enable bytes occupy indices ff30 to ff34, eight bits, read-write.
// RL11: Sense condition sets the flag; CPU request forwarded only while line enabled.
//
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
module eis_irq_ctrl
   import eis_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // External request pins
   input wire logic [N_LINES-1:0] extRequestPin,
   // Requests of the other interrupt sources
   input wire logic [N_PERIPH-1:0] periphReq,
   // CPU side
   output logic [N_LINES-1:0] cpuIrqReq,
   output logic evIrq,
   // Transfer controller side
   output logic [N_SRC-1:0] xferActivate,
   input wire logic xferDone,
   input wire logic [SRC_W-1:0] xferSrc,
   input wire logic xferDisableAfter,
   input wire logic xferCountEnd
);

   // Registers
   logic [BYTE_W-1:0] irqSenseHigh;
   logic [BYTE_W-1:0] irqSenseLow;
   logic [BYTE_W-1:0] irqLineEnables;
   logic [BYTE_W-1:0] irqPendingFlags;
   logic [N_SRC-1:0] actFlat;
   logic [EV_W-1:0] evStatus;
   logic [EV_W-1:0] evMask;
   logic [EV_W-1:0] evCaptured;

   // Bus decode
   logic [IDX_W-1:0] regIdx;
   eis_sel_t regSel;
   logic [ACT_NUM_W-1:0] actNum;
   logic setupPhase;
   logic accessPhase;
   logic wrByte;
   logic rdDone;
   logic [BYTE_W-1:0] wrData;

   // Internal events
   logic [N_LINES-1:0] senseHit;
   logic [N_LINES-1:0] next_pending;
   logic [N_SRC-1:0] next_act;
   logic [N_SRC-1:0] srcReq;
   logic [N_SRC-1:0] actBySrc;
   logic [N_LINES-1:0] lineReq;
   logic [N_LINES-1:0] lineAct;
   logic autoClear;
   logic [EV_W-1:0] evSet;

   // One-hot select of the addressed register
   function automatic eis_sel_t decodeSel(input logic [IDX_W-1:0] idx,
                                          input logic [1:0] lowBits);
      eis_sel_t sel;
      sel = SEL_NONE;
      if (lowBits == WORD_ALIGN) begin
         if (idx == IDX_SENSE_HI) begin
            sel = SEL_SENSE_HI;
         end else if (idx == IDX_SENSE_LO) begin
            sel = SEL_SENSE_LO;
         end else if (idx == IDX_LINE_EN) begin
            sel = SEL_LINE_EN;
         end else if (idx == IDX_PEND) begin
            sel = SEL_PEND;
         end else if (idx >= IDX_ACT_FIRST && idx <= IDX_ACT_LAST) begin
            sel = SEL_ACT;
         end else if (idx == IDX_EV_STAT) begin
            sel = SEL_EV_STAT;
         end else if (idx == IDX_EV_MASK) begin
            sel = SEL_EV_MASK;
         end
      end
      return sel;
   endfunction

   assign regIdx = paddr[ADDR_W-1:2];
   assign regSel = decodeSel(regIdx, paddr[1:0]);
   assign actNum = ACT_NUM_W'(regIdx - IDX_ACT_FIRST);
   assign setupPhase = psel & ~penable;
   assign accessPhase = psel & penable;
   assign wrData = pwdata[BYTE_W-1:0];

   // Zero wait states; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = accessPhase & (regSel == SEL_NONE);

   // Data sits in the low byte lane only
   assign wrByte = accessPhase & pwrite & pstrb[0];
   assign rdDone = accessPhase & ~pwrite & (regSel == SEL_EV_STAT);

   // Sense detection of the pins
   eis_sense_detect u_sense (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .extRequestPin(extRequestPin),
      .senseSel({irqSenseHigh, irqSenseLow}),
      .senseHit(senseHit)
   );

   // RL1: upper four sense fields
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         irqSenseHigh <= RST_BYTE;
      end else if (wrByte && regSel == SEL_SENSE_HI) begin
         irqSenseHigh <= wrData;
      end
   end

   // RL3: lower sense byte, reset zero
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         irqSenseLow <= RST_BYTE;
      end else if (wrByte && regSel == SEL_SENSE_LO) begin
         irqSenseLow <= wrData;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         irqLineEnables <= RST_BYTE;
      end else if (wrByte && regSel == SEL_LINE_EN) begin
         irqLineEnables <= wrData;
      end
   end

   // RL5: write of zero clears, write of one keeps; a new hit wins over the clear
   always_comb begin
      next_pending = irqPendingFlags;
      if (wrByte && regSel == SEL_PEND) begin
         next_pending = irqPendingFlags & wrData;
      end
      // RL11: sense condition sets flag
      next_pending = next_pending | senseHit;
   end

   // RL4: one flag per input
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         irqPendingFlags <= RST_BYTE;
      end else begin
         irqPendingFlags <= next_pending;
      end
   end

   // RL7: hardware clear after the final or disabling transfer
   assign autoClear = xferDone & (xferDisableAfter | xferCountEnd) & (xferSrc < SRC_LIMIT);

   // Enable bytes: a hardware clear wins over a software write in the same cycle
   always_comb begin
      next_act = actFlat;
      // RL10: byte addressed by index offset
      if (wrByte && regSel == SEL_ACT) begin
         next_act[actNum*BYTE_W +: BYTE_W] = wrData;
      end
      // RL8: held unless the clear condition holds
      if (autoClear) begin
         next_act[srcPos(xferSrc)] = 1'b0;
      end
   end

   // RL6: activation enables, reset zero
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         actFlat <= RST_ACT;
      end else begin
         actFlat <= next_act;
      end
   end

   // RL9: reversed bit order within each byte
   always_comb begin
      for (int s = 0; s < N_SRC; s++) begin
         actBySrc[s] = actFlat[srcPos(SRC_W'(s))];
      end
   end

   // RL11: only enabled lines raise requests
   assign lineReq = irqPendingFlags & irqLineEnables;
   assign lineAct = actBySrc[N_LINES-1:0];
   assign srcReq = {periphReq, lineReq};

   // Lines routed to the transfer controller are withheld from the CPU
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cpuIrqReq <= RST_BYTE;
      end else begin
         cpuIrqReq <= lineReq & ~lineAct;
      end
   end

   // RL6: source triggers the transfer controller
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         xferActivate <= RST_ACT;
      end else begin
         xferActivate <= srcReq & actBySrc;
      end
   end

   // Events: a new pending flag, and a hardware clear of an enable
   assign evSet[EV_PEND_BIT] = |(senseHit & ~irqPendingFlags);
   assign evSet[EV_ACLR_BIT] = autoClear;

   // Only bits seen by the read are cleared, so an event after the setup edge is kept
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         evStatus <= RST_EV;
      end else if (rdDone) begin
         evStatus <= (evStatus & ~evCaptured) | evSet;
      end else begin
         evStatus <= evStatus | evSet;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         evMask <= RST_EV;
      end else if (wrByte && regSel == SEL_EV_MASK) begin
         evMask <= wrData[EV_W-1:0];
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         evIrq <= 1'b0;
      end else begin
         evIrq <= |((evStatus | evSet) & evMask);
      end
   end

   // Read data captured in the setup cycle, stable through the access phase
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         prdata <= RST_WORD;
         evCaptured <= RST_EV;
      end else if (setupPhase) begin
         evCaptured <= evStatus;
         unique case (regSel)
            SEL_SENSE_HI: prdata <= DATA_W'(irqSenseHigh);
            SEL_SENSE_LO: prdata <= DATA_W'(irqSenseLow);
            SEL_LINE_EN: prdata <= DATA_W'(irqLineEnables);
            SEL_PEND: prdata <= DATA_W'(irqPendingFlags);
            SEL_ACT: prdata <= DATA_W'(actFlat[actNum*BYTE_W +: BYTE_W]);
            SEL_EV_STAT: prdata <= DATA_W'(evStatus);
            SEL_EV_MASK: prdata <= DATA_W'(evMask);
            SEL_NONE: prdata <= RST_WORD;
         endcase
      end
   end

endmodule

// ### logic/eis_pkg.sv
// Shared constants, types and helpers for the external request controller
package eis_pkg;

   // Bus geometry: register index is the byte address divided by four
   localparam int ADDR_W = 20;
   localparam int IDX_W = 18;
   localparam int BYTE_W = 8;
   localparam int DATA_W = 32;
   localparam logic [1:0] WORD_ALIGN = 2'h0;

   // Register indices
   localparam logic [IDX_W-1:0] IDX_SENSE_HI = 18'h0ff2c;
   localparam logic [IDX_W-1:0] IDX_SENSE_LO = 18'h0ff2d;
   localparam logic [IDX_W-1:0] IDX_LINE_EN = 18'h0ff2e;
   localparam logic [IDX_W-1:0] IDX_PEND = 18'h0ff2f;
   localparam logic [IDX_W-1:0] IDX_ACT_FIRST = 18'h0ff30;
   localparam logic [IDX_W-1:0] IDX_ACT_LAST = 18'h0ff34;
   localparam logic [IDX_W-1:0] IDX_EV_STAT = 18'h0ff36;
   localparam logic [IDX_W-1:0] IDX_EV_MASK = 18'h0ff37;

   // Sizes
   localparam int N_LINES = 8;
   localparam int N_ACT_BYTES = 5;
   localparam int N_SRC = 40;
   localparam int N_PERIPH = 32;
   localparam int SRC_W = 6;
   localparam int ACT_NUM_W = 3;
   localparam int EV_W = 2;
   localparam logic [SRC_W-1:0] SRC_LIMIT = 6'h28;

   // Reset values
   localparam logic [BYTE_W-1:0] RST_BYTE = 8'h00;
   localparam logic [N_SRC-1:0] RST_ACT = 40'h00_0000_0000;
   localparam logic [EV_W-1:0] RST_EV = 2'h0;
   localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;

   // Event status bit positions
   localparam int EV_PEND_BIT = 0;
   localparam int EV_ACLR_BIT = 1;

   // Sense field codes
   typedef enum logic [1:0] {
      SENSE_LOW = 2'h0,
      SENSE_FALL = 2'h1,
      SENSE_RISE = 2'h2,
      SENSE_BOTH = 2'h3
   } eis_sense_t;

   // Register select, one-hot
   typedef enum logic [7:0] {
      SEL_NONE = 8'h01,
      SEL_SENSE_HI = 8'h02,
      SEL_SENSE_LO = 8'h04,
      SEL_LINE_EN = 8'h08,
      SEL_PEND = 8'h10,
      SEL_ACT = 8'h20,
      SEL_EV_STAT = 8'h40,
      SEL_EV_MASK = 8'h80
   } eis_sel_t;

   // Request condition of one input under a sense code
   function automatic logic senseMatch(input logic [1:0] mode, input logic cur,
                                       input logic prev);
      logic hit;
      hit = 1'b0;
      unique case (eis_sense_t'(mode))
         SENSE_LOW: hit = ~cur;
         SENSE_FALL: hit = prev & ~cur;
         SENSE_RISE: hit = ~prev & cur;
         SENSE_BOTH: hit = prev ^ cur;
      endcase
      return hit;
   endfunction

   // Position of a source in the flat enable vector: bit 7 of a byte is its first source
   function automatic logic [SRC_W-1:0] srcPos(input logic [SRC_W-1:0] src);
      return {src[SRC_W-1:3], ~src[2:0]};
   endfunction

endpackage

// ### logic/eis_sense_detect.sv
// Pin synchroniser and per-input sense detection for the eight request pins
`timescale 1ns/10ps
module eis_sense_detect
   import eis_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // Pins and sense fields
   input wire logic [N_LINES-1:0] extRequestPin,
   input wire logic [2*N_LINES-1:0] senseSel,
   // Detected request conditions
   output logic [N_LINES-1:0] senseHit
);

   logic [N_LINES-1:0] pinMeta;
   logic [N_LINES-1:0] pinSync;
   logic [N_LINES-1:0] pinPrev;

   // Two-stage synchroniser; pins idle high so reset to one avoids a false edge
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pinMeta <= {N_LINES{1'b1}};
         pinSync <= {N_LINES{1'b1}};
         pinPrev <= {N_LINES{1'b1}};
      end else begin
         pinMeta <= extRequestPin;
         pinSync <= pinMeta;
         pinPrev <= pinSync;
      end
   end

   // RL2: decode sense codes
   always_comb begin
      for (int i = 0; i < N_LINES; i++) begin
         senseHit[i] = senseMatch(senseSel[2*i +: 2], pinSync[i], pinPrev[i]);
      end
   end

endmodule

// ### sim/eis_irq_chk.sv
// Port checker for the external request controller
`timescale 1ns/10ps
module eis_irq_chk
   import eis_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Requests
   input wire logic [N_PERIPH-1:0] periphReq,
   input wire logic [N_LINES-1:0] cpuIrqReq,
   input wire logic [N_SRC-1:0] xferActivate,
   input wire logic xferDone,
   input wire logic [SRC_W-1:0] xferSrc,
   input wire logic xferDisableAfter,
   input wire logic xferCountEnd
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);
   chk_zero_wait: assert property (pready) else $error("pready low");
   chk_err_phase: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
   chk_upper_zero: assert property (prdata[31:8] == 24'h0) else $error("prdata upper set");
   chk_unmapped_zero: assert property (psel && penable && pslverr && !pwrite
      |-> prdata == 32'h0) else $error("refused read not zero");
   chk_route_exclusive: assert property ((cpuIrqReq & xferActivate[7:0]) == 8'h00)
      else $error("request on both routes");
   chk_periph_needs_req: assert property ((xferActivate[39:8] & ~$past(periphReq)) == 32'h0)
      else $error("activation without request");
   chk_auto_clear: assert property (xferDone && (xferDisableAfter || xferCountEnd)
      && xferSrc < SRC_LIMIT |-> ##2 !xferActivate[$past(xferSrc, 2)])
      else $error("enable not cleared");
   chk_enable_holds: assert property (xferDone && !xferDisableAfter && !xferCountEnd
      && xferSrc < 6'h08 && xferActivate[xferSrc] |-> ##2 xferActivate[$past(xferSrc, 2)])
      else $error("enable lost");
endmodule
bind eis_irq_ctrl eis_irq_chk u_chk (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .periphReq(periphReq), .cpuIrqReq(cpuIrqReq), .xferActivate(xferActivate),
   .xferDone(xferDone), .xferSrc(xferSrc), .xferDisableAfter(xferDisableAfter),
   .xferCountEnd(xferCountEnd));

// ### sim/eis_xfer_model.sv
// Transfer controller model serving one chosen source
`timescale 1ns/10ps
module eis_xfer_model
   import eis_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // Scenario controls
   input wire logic [SRC_W-1:0] cfgSrc,
   input wire logic cfgDis,
   input wire logic cfgEnd,
   // Block side
   input wire logic [N_SRC-1:0] xferActivate,
   output logic xferDone,
   output logic [SRC_W-1:0] xferSrc,
   output logic xferDisableAfter,
   output logic xferCountEnd
);
   logic [1:0] waitCnt;
   logic busy;
   assign busy = cfgSrc < SRC_LIMIT && xferActivate[cfgSrc] && !xferDone;
   // Done qualified in its cycle; idle lines toggle so stale values never pass
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         waitCnt <= 2'h0;
         xferDone <= 1'b0;
         {xferSrc, xferDisableAfter, xferCountEnd} <= 8'h00;
      end else begin
         waitCnt <= busy ? waitCnt + 2'h1 : 2'h0;
         xferDone <= busy && waitCnt == 2'h3;
         xferSrc <= busy && waitCnt == 2'h3 ? cfgSrc : ~xferSrc;
         xferDisableAfter <= busy && waitCnt == 2'h3 ? cfgDis : ~xferDisableAfter;
         xferCountEnd <= busy && waitCnt == 2'h3 ? cfgEnd : ~xferCountEnd;
      end
   end
endmodule

// ### sim/tb_ext_irq_sense_and_dtc_enable.sv
// Self-checking bench for the external request controller
`timescale 1ns/10ps
module tb_ext_irq_sense_and_dtc_enable;
   import eis_pkg::*;
   logic sys_clk, arst_n, psel, penable, pwrite, pready, pslverr, evIrq, lastErr;
   logic xferDone, xferDisableAfter, xferCountEnd, cfgDis, cfgEnd;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata;
   logic [3:0] pstrb;
   logic [7:0] pins, cpuIrqReq, rd;
   logic [N_PERIPH-1:0] periphReq;
   logic [N_SRC-1:0] xferActivate;
   logic [SRC_W-1:0] xferSrc, cfgSrc;
   // Low address bits of the next transfer; nonzero makes it misaligned
   logic [1:0] misal = 2'h0;
   int bad_count = 0;
   int n_checks = 0;
   int cycles = 0;
   eis_irq_ctrl u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .extRequestPin(pins), .periphReq(periphReq),
      .cpuIrqReq(cpuIrqReq), .evIrq(evIrq), .xferActivate(xferActivate),
      .xferDone(xferDone), .xferSrc(xferSrc), .xferDisableAfter(xferDisableAfter),
      .xferCountEnd(xferCountEnd));
   eis_xfer_model u_xfer (.sys_clk(sys_clk), .arst_n(arst_n), .cfgSrc(cfgSrc),
      .cfgDis(cfgDis), .cfgEnd(cfgEnd), .xferActivate(xferActivate), .xferDone(xferDone),
      .xferSrc(xferSrc), .xferDisableAfter(xferDisableAfter), .xferCountEnd(xferCountEnd));
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   task automatic test_done();
      $display("Checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Whole run needs a few hundred cycles
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         test_done();
      end
   end
   task automatic cmp(input logic [39:0] g, input logic [39:0] e);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic apb(input logic w, input logic [IDX_W-1:0] idx, input logic [7:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, WORD_ALIGN | misal};
      pwdata <= {24'h00_0000, d};
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      rd = prdata[7:0];
      lastErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rdc(input logic [IDX_W-1:0] idx, input logic [7:0] e);
      apb(1'b0, idx, 8'h00);
      cmp({32'h0, rd}, {32'h0, e});
   endtask
   task automatic t_regs();
      logic [IDX_W-1:0] i;
      for (i = IDX_SENSE_HI; i <= IDX_EV_MASK; i++) begin
         apb(1'b0, i, 8'h00);
         cmp({32'h0, rd}, 40'h0);
         cmp({39'h0, lastErr}, {39'h0, i == 18'h0ff35});
      end
      for (i = IDX_SENSE_HI; i <= IDX_ACT_LAST; i++) begin
         apb(1'b1, i, 8'ha5);
         rdc(i, i == IDX_PEND ? 8'h00 : 8'ha5);
         apb(1'b1, i, 8'h00);
      end
      // Refused writes: low strobe clear, then a misaligned address
      pstrb <= 4'h0;
      apb(1'b1, IDX_LINE_EN, 8'hff);
      pstrb <= 4'hf;
      rdc(IDX_LINE_EN, 8'h00);
      misal = 2'h1;
      apb(1'b1, IDX_LINE_EN, 8'hff);
      misal = 2'h0;
      cmp({39'h0, lastErr}, 40'h1);
      rdc(IDX_LINE_EN, 8'h00);
      $display("Test regs done");
   endtask
   task automatic t_sense();
      logic [15:0] sw;
      logic [7:0] ma, mb, mc;
      logic [1:0] m;
      apb(1'b1, IDX_LINE_EN, 8'hff);
      for (int r = 0; r < 4; r++) begin
         for (int n = 0; n < 8; n++) begin
            m = 2'((n / 2 + r) % 4);
            sw[2*n +: 2] = m;
            ma[n] = m != SENSE_RISE;
            mc[n] = m == SENSE_LOW;
            mb[n] = m != SENSE_FALL;
         end
         apb(1'b1, IDX_SENSE_LO, sw[7:0]);
         apb(1'b1, IDX_SENSE_HI, sw[15:8]);
         apb(1'b1, IDX_PEND, 8'h00);
         pins <= 8'h00;
         tick(6);
         rdc(IDX_PEND, ma);
         cmp({32'h0, cpuIrqReq}, {32'h0, ma});
         apb(1'b1, IDX_PEND, 8'h00);
         rdc(IDX_PEND, mc);
         pins <= 8'hff;
         tick(6);
         rdc(IDX_PEND, mb);
         apb(1'b1, IDX_PEND, 8'h00);
         rdc(IDX_PEND, 8'h00);
      end
      $display("Test sense done");
   endtask
   task automatic t_xfer();
      apb(1'b1, IDX_SENSE_LO, 8'h55);
      apb(1'b1, IDX_SENSE_HI, 8'h55);
      apb(1'b1, IDX_LINE_EN, 8'h8f);
      apb(1'b1, IDX_ACT_FIRST, 8'h81);
      apb(1'b0, IDX_EV_STAT, 8'h00);
      cfgSrc <= 6'h00;
      pins <= 8'h00;
      tick(12);
      cmp({32'h0, cpuIrqReq}, 40'h0e);
      cmp(xferActivate, 40'h81);
      rdc(IDX_ACT_FIRST, 8'h81);
      cmp({39'h0, evIrq}, 40'h0);
      apb(1'b1, IDX_EV_MASK, 8'h03);
      tick(2);
      cmp({39'h0, evIrq}, 40'h1);
      cfgEnd <= 1'b1;
      tick(8);
      rdc(IDX_ACT_FIRST, 8'h01);
      cmp(xferActivate, 40'h80);
      cmp({32'h0, cpuIrqReq}, 40'h0f);
      rdc(IDX_EV_STAT, 8'h03);
      tick(2);
      cmp({39'h0, evIrq}, 40'h0);
      apb(1'b1, IDX_ACT_FIRST + 18'h1, 8'h80);
      periphReq <= 32'h0000_0001;
      tick(3);
      cmp(xferActivate, 40'h180);
      {cfgSrc, cfgDis, cfgEnd} <= 8'h22;
      tick(8);
      rdc(IDX_ACT_FIRST + 18'h1, 8'h00);
      cmp(xferActivate, 40'h80);
      $display("Test transfer done");
   endtask
   initial begin
      arst_n = 1'b0;
      {psel, penable, pwrite, cfgDis, cfgEnd} = 5'h00;
      {paddr, pwdata, periphReq} = 84'h0;
      pstrb = 4'hf;
      pins = 8'hff;
      cfgSrc = 6'h3f;
      repeat (12) @(posedge sys_clk);
      arst_n <= 1'b1;
      @(posedge sys_clk);
      t_regs();
      t_sense();
      t_xfer();
      test_done();
   end
endmodule
